//--- logic/host_pin_pkg.sv
// Package of constants for the host port strap and pin role block
// Function
// - In SPI slave mode the device answers only while chip select is low.
// - In SPI master mode chip select is driven during auto-configuration, then turned into an input.
// - The second interface strap is sampled at the rising edge of reset and forms the mode with the first.
// - After reset the first strap pin becomes chip select and the second becomes MISO.
// - In SPI slave mode the device drives read data on MISO during reads.
// - In SPI master mode the device captures EEPROM data from MISO during auto-configuration.
// - In SPI master mode the device drives the serial clock pin to time EEPROM accesses.
// - In I2C slave mode the data pin is the bidirectional SDA line.
// - A high test strap at the rising edge of reset enables factory test mode.
package host_pin_pkg;

  typedef enum logic [1:0] {
    MODE_I2C_SLAVE,
    MODE_SPI_SLAVE,
    MODE_SPI_MASTER,
    MODE_RESERVED
  } host_mode_e;

  // Strap code (high strap, low strap) for each mode
  localparam logic [1:0] CODE_I2C_SLAVE  = 2'h0;
  localparam logic [1:0] CODE_SPI_SLAVE  = 2'h1;
  localparam logic [1:0] CODE_SPI_MASTER = 2'h2;

  localparam int SYNC_STAGES  = 2;
  localparam int CLK_DIV      = 16;
  localparam int BOOT_BYTES   = 4;
  localparam logic [7:0] EEPROM_READ_CMD = 8'h03;
  // Read command byte followed by a 24-bit start address
  localparam int CMD_BITS     = 32;

endpackage : host_pin_pkg

//--- logic/pin_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : pin_sync

//--- logic/host_pin_roles.sv
// Strap capture and serial pin roles of the host port
`timescale 1ns/1ns
module host_pin_roles #(
  parameter int DIV   = host_pin_pkg::CLK_DIV,
  parameter int BYTES = host_pin_pkg::BOOT_BYTES
) (
  input  wire logic                     core_clk,
  input  wire logic                     resetn,
  input  wire logic                     strap_low_cs_i,
  output logic                          strap_low_cs_o,
  output logic                          strap_low_cs_oe,
  input  wire logic                     strap_high_miso_i,
  output logic                          strap_high_miso_o,
  output logic                          strap_high_miso_oe,
  input  wire logic                     sclk_i,
  output logic                          sclk_o,
  output logic                          sclk_oe,
  input  wire logic                     sda_i,
  output logic                          sda_o,
  output logic                          sda_oe,
  input  wire logic                     test_strap,
  input  wire logic                     slave_rd_bit,
  input  wire logic                     slave_rd_en,
  input  wire logic                     sda_drive_low,
  output host_pin_pkg::host_mode_e      mode,
  output logic                          test_mode,
  output logic                          boot_done,
  output logic                          boot_valid,
  output logic [7:0]                    boot_byte,
  output logic                          cs_active,
  output logic                          sclk_rise,
  output logic                          mosi_bit
);
  import host_pin_pkg::*;

  // The link clock is split into two equal halves, so DIV must be even
  if (DIV < 2 || DIV % 2 != 0) begin : g_div_check
    $error("DIV must be even and at least 2");
  end
  if (BYTES < 1) begin : g_bytes_check
    $error("BYTES must be at least 1");
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [4:0] raw;
  logic [4:0] syn;
  assign raw = {test_strap, sda_i, sclk_i, strap_high_miso_i,
                strap_low_cs_i};
  pin_sync #(.WIDTH(5)) u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .async_in (raw),
    .sync_out (syn)
  );
  logic cs_s, miso_s, sclk_s, sda_s, test_s;
  assign {test_s, sda_s, sclk_s, miso_s, cs_s} = syn;

  // ------------------------------------------------------------
  // Strap capture at reset release
  // ------------------------------------------------------------
  // Synchronised straps need SYNC_STAGES cycles to flush out of reset,
  // so the capture waits that long after the release.
  logic [1:0] rel_cnt_q;
  logic       captured_q;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rel_cnt_q  <= '0;
      captured_q <= 1'b0;
      mode       <= MODE_I2C_SLAVE;
      test_mode  <= 1'b0;
    end else if (!captured_q) begin
      rel_cnt_q <= rel_cnt_q + 2'h1;
      if (rel_cnt_q == 2'(SYNC_STAGES)) begin
        captured_q <= 1'b1;
        test_mode  <= test_s;
        unique case ({miso_s, cs_s})
          CODE_I2C_SLAVE:  mode <= MODE_I2C_SLAVE;
          CODE_SPI_SLAVE:  mode <= MODE_SPI_SLAVE;
          CODE_SPI_MASTER: mode <= MODE_SPI_MASTER;
          default:         mode <= MODE_RESERVED;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // SPI slave side and link edge detect
  // ------------------------------------------------------------
  logic sclk_d_q;
  // The delayed copy resets to the idle low level of the link clock, so
  // no false rising edge follows reset
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sclk_d_q  <= 1'b0;
      sclk_rise <= 1'b0;
      mosi_bit  <= 1'b0;
    end else begin
      sclk_d_q  <= sclk_s;
      sclk_rise <= sclk_s & ~sclk_d_q & captured_q;
      mosi_bit  <= sda_s;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cs_active <= 1'b0;
    end else begin
      cs_active <= captured_q & (mode == MODE_SPI_SLAVE) & ~cs_s;
    end
  end

  // ------------------------------------------------------------
  // Auto-configuration master: read BYTES from EEPROM at address 0
  // ------------------------------------------------------------
  typedef enum logic [1:0] {BOOT_IDLE, BOOT_XFER, BOOT_END} boot_e;
  boot_e boot_q;
  localparam int TOTAL_BITS = CMD_BITS + 8 * BYTES;
  logic [$clog2(DIV)-1:0]        div_q;
  logic [$clog2(TOTAL_BITS+1)-1:0] bit_q;
  // Command and an all-zero address: the boot image starts at the bottom
  logic [CMD_BITS-1:0] cmd_q;
  logic [7:0]  shift_q;
  logic        tick;
  assign tick = (div_q == ($clog2(DIV))'(DIV/2 - 1));

  always_ff @(posedge core_clk) begin
    if (!resetn || boot_q != BOOT_XFER || tick) div_q <= '0;
    else div_q <= div_q + 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      boot_q     <= BOOT_IDLE;
      bit_q      <= '0;
      cmd_q      <= '0;
      shift_q    <= '0;
      sclk_o     <= 1'b0;
      boot_done  <= 1'b0;
      boot_valid <= 1'b0;
      boot_byte  <= '0;
    end else begin
      boot_valid <= 1'b0;
      unique case (boot_q)
        BOOT_IDLE: if (captured_q) begin
          if (mode == MODE_SPI_MASTER) begin
            boot_q <= BOOT_XFER;
            cmd_q  <= {EEPROM_READ_CMD, {(CMD_BITS-8){1'b0}}};
          end else begin
            boot_q <= BOOT_END;
          end
        end
        // Shift out on the falling edge and sample on the rising one, so the EEPROM
        // gets DIV/2 - 1 cycles of setup and the synchronised sample DIV/2 - 2
        BOOT_XFER: if (tick) begin
          sclk_o <= ~sclk_o;
          if (sclk_o) begin
            cmd_q <= {cmd_q[CMD_BITS-2:0], 1'b0};
            bit_q <= bit_q + 1'b1;
            if (bit_q == ($bits(bit_q))'(TOTAL_BITS - 1)) boot_q <= BOOT_END;
          end else if (bit_q >= ($bits(bit_q))'(CMD_BITS)) begin
            shift_q <= {shift_q[6:0], miso_s};
            if (bit_q[2:0] == 3'h7) begin
              boot_valid <= 1'b1;
              boot_byte  <= {shift_q[6:0], miso_s};
            end
          end
        end
        BOOT_END: boot_done <= 1'b1;
        default: boot_q <= BOOT_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  // Every enable is registered so the pads never see a decode glitch;
  // the price is one cycle of lag behind the boot state
  logic in_boot;
  assign in_boot = (boot_q == BOOT_XFER);

  // Chip select is ours only while the boot read runs
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      strap_low_cs_o  <= 1'b1;
      strap_low_cs_oe <= 1'b0;
    end else begin
      strap_low_cs_o  <= ~in_boot;
      strap_low_cs_oe <= in_boot;
    end
  end

  // Read data toward the external master, only while it selects us
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      strap_high_miso_o  <= 1'b0;
      strap_high_miso_oe <= 1'b0;
    end else begin
      strap_high_miso_o  <= slave_rd_bit;
      strap_high_miso_oe <= cs_active & slave_rd_en;
    end
  end

  // The clock pin is an input in every mode but the boot read
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sclk_oe <= 1'b0;
    end else begin
      sclk_oe <= in_boot;
    end
  end

  // Data pin: command bits during boot, open drain toward the I2C master
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sda_o  <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      sda_o  <= in_boot ? cmd_q[CMD_BITS-1] : 1'b0;
      sda_oe <= in_boot | (captured_q & (mode == MODE_I2C_SLAVE)
                & sda_drive_low);
    end
  end

endmodule : host_pin_roles

//--- test/host_pin_roles_props.sv
// Checker for strap capture and serial pin roles
`timescale 1ns/1ns
module host_pin_roles_props
  import host_pin_pkg::*;
#(
  parameter int DIV   = 16,
  parameter int BYTES = 4
) (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       test_strap,
  input wire logic       test_mode,
  input wire logic       strap_low_cs_i,
  input wire logic       strap_low_cs_oe,
  input wire logic       strap_high_miso_i,
  input wire logic       strap_high_miso_oe,
  input wire logic       sclk_o,
  input wire logic       sclk_oe,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       boot_done,
  input wire logic       boot_valid,
  input wire logic       cs_active,
  input wire host_mode_e mode
);
  // The half period check counts DIV/2 - 1 cycles as a plain number
  if (DIV != 16) begin : g_div_check
    $error("half period check expects DIV of 16");
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Cycles since release; saturates once the straps have settled
  logic [2:0] cnt_q;
  always_ff @(posedge core_clk) begin
    if (!resetn) cnt_q <= 3'h0;
    else if (cnt_q != 3'h7) cnt_q <= cnt_q + 3'h1;
  end
  a_mode_capture: assert property (
    cnt_q == 3'h6 |->
      mode == host_mode_e'({strap_high_miso_i, strap_low_cs_i})
      && test_mode == test_strap)
    else $error("mode capture wrong");
  a_mode_hold: assert property (
    cnt_q == 3'h7 |-> $stable(mode) && $stable(test_mode))
    else $error("mode moved");
  a_cs_slave_only: assert property (
    cs_active |-> mode == MODE_SPI_SLAVE) else $error("select outside slave");
  a_miso_select: assert property (
    strap_high_miso_oe |-> $past(cs_active))
    else $error("miso driven while not selected");
  a_cs_boot_drive: assert property (
    strap_low_cs_oe |-> mode == MODE_SPI_MASTER && !boot_done)
    else $error("cs driven");
  a_miso_slave: assert property (
    strap_high_miso_oe |-> mode == MODE_SPI_SLAVE) else $error("miso driven");
  a_sclk_owner: assert property (
    sclk_oe |-> mode == MODE_SPI_MASTER) else $error("clock driven");
  a_sda_open: assert property (
    sda_oe && mode == MODE_I2C_SLAVE |-> !sda_o)
    else $error("data driven high");
  a_boot_release: assert property (
    boot_done |-> !sclk_oe && !strap_low_cs_oe) else $error("pins kept");
  a_sclk_half: assert property (
    sclk_oe && $changed(sclk_o) |=> (!sclk_oe || $stable(sclk_o))[*7])
    else $error("clock half period short");
  a_valid_master: assert property (
    boot_valid |-> mode == MODE_SPI_MASTER)
    else $error("byte outside boot");
  cover property (boot_valid);
  cover property (cs_active && strap_high_miso_oe);
  cover property (sda_oe && mode == MODE_I2C_SLAVE);
endmodule : host_pin_roles_props

bind host_pin_roles host_pin_roles_props #(.DIV(DIV), .BYTES(BYTES)) u_props (
  .core_clk, .resetn, .test_strap, .test_mode, .strap_low_cs_i, .sda_o,
  .strap_low_cs_oe, .strap_high_miso_i, .strap_high_miso_oe, .sclk_o,
  .sclk_oe, .sda_oe, .boot_done, .boot_valid, .cs_active, .mode);

//--- test/boot_eeprom_model.sv
// Serial boot memory model answering the auto-configuration read
`timescale 1ns/1ns
module boot_eeprom_model (
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        mosi,
  input  wire logic [7:0]  rd_byte,
  output logic             miso,
  output logic [31:0]      cmd
);
  int n = 0;
  initial miso = 1'b0;
  initial cmd = 32'h0;
  always @(posedge sclk) if (!cs_n) begin
    if (n < 32) cmd = {cmd[30:0], mosi};
    n = n + 1;
  end
  // Data leaves on the falling clock, MSB first, after the command
  always @(negedge sclk) if (!cs_n && n >= 32) miso = rd_byte[7 - (n - 32) % 8];
  // Deselected: no held level, so a late sample cannot pass by luck
  always @(posedge cs_n) begin
    n = 0;
    miso = ~miso;
  end
endmodule : boot_eeprom_model

//--- test/host_pin_roles_tb_top.sv
// Testbench for the host port strap and pin role block
`timescale 1ns/1ns
module host_pin_roles_tb_top;
  import host_pin_pkg::*;
  logic core_clk, resetn, tb_cs, tb_miso, tb_sclk, tb_sda, eep_on, eep_miso;
  logic test_strap, slave_rd_bit, slave_rd_en, sda_drive_low, test_mode;
  logic strap_low_cs_o, strap_low_cs_oe, strap_high_miso_o, sda_o, sda_oe;
  logic strap_high_miso_oe, sclk_o, sclk_oe, boot_done, boot_valid;
  logic cs_active, sclk_rise, mosi_bit;
  logic [7:0] boot_byte, rd_byte;
  logic [31:0] cmd;
  host_mode_e mode;
  int n_errors = 0;
  int checked = 0;
  logic exp_bit[$];
  logic [7:0] exp_byte[$];
  wire strap_low_cs_i = strap_low_cs_oe ? strap_low_cs_o : tb_cs;
  wire strap_high_miso_i = strap_high_miso_oe ? strap_high_miso_o
                         : (eep_on ? eep_miso : tb_miso);
  wire sclk_i = sclk_oe ? sclk_o : tb_sclk;
  wire sda_i = sda_oe ? sda_o : tb_sda;
  host_pin_roles #(.DIV(16), .BYTES(1)) u_host_pin_roles (.core_clk, .resetn,
    .strap_low_cs_i, .strap_low_cs_o, .strap_low_cs_oe, .strap_high_miso_i,
    .strap_high_miso_o, .strap_high_miso_oe, .sclk_i, .sclk_o, .sclk_oe,
    .sda_i, .sda_o, .sda_oe, .test_strap, .slave_rd_bit, .slave_rd_en,
    .sda_drive_low, .mode, .test_mode, .boot_done, .boot_valid, .boot_byte,
    .cs_active, .sclk_rise, .mosi_bit);
  boot_eeprom_model u_boot_eeprom_model (.cs_n(strap_low_cs_i), .sclk(sclk_i),
    .mosi(sda_i), .rd_byte, .miso(eep_miso), .cmd);
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic boot(logic [1:0] code, logic tst);
    @(negedge core_clk);
    resetn = 1'b0;
    eep_on = 1'b0;
    tb_cs = code[0];
    tb_miso = code[1];
    test_strap = tst;
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    repeat (8) @(negedge core_clk);
    chk("mode", mode, code);
    chk("test_mode", test_mode, tst);
    tb_cs = 1'b1;
    test_strap = 1'b0;
    eep_on = (code == 2'h2);
  endtask : boot
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Results are compared as they appear, against notes made when driven
  always @(negedge core_clk) begin
    if (sclk_rise && mode == MODE_SPI_SLAVE) begin
      if (exp_bit.size() > 0)
        chk("mosi_bit", mosi_bit, exp_bit.pop_front());
      else
        chk("spare link edge", 1'b1, 1'b0);
    end
    if (boot_valid) begin
      if (exp_byte.size() > 0)
        chk("boot_byte", boot_byte, exp_byte.pop_front());
      else
        chk("spare boot byte", 1'b1, 1'b0);
    end
  end
  initial begin
    repeat (50000) @(posedge core_clk);
    n_errors++;
    print_verdict();
  end
  initial begin
    {resetn, tb_cs, tb_miso, tb_sclk, tb_sda, eep_on} = 6'h02;
    {test_strap, slave_rd_bit, slave_rd_en, sda_drive_low} = 4'h0;
    void'($urandom(32'hcd3e4e40));
    rd_byte = 8'($urandom);
    boot(2'h3, 1'b0);
    boot(2'h0, 1'b1);
    sda_drive_low = 1'b1;
    repeat (4) @(negedge core_clk);
    chk("sda_oe", sda_oe, 1);
    chk("sda_o", sda_o, 0);
    chk("sclk_oe", sclk_oe, 0);
    // The I2C master clocks the shared pin; the block only listens
    #61 tb_sclk = 1'b1;
    #64 tb_sclk = 1'b0;
    sda_drive_low = 1'b0;
    repeat (4) @(negedge core_clk);
    chk("sclk_oe", sclk_oe, 0);
    chk("sda_oe", sda_oe, 0);
    boot(2'h1, 1'b0);
    @(negedge core_clk);
    tb_cs = 1'b0;
    slave_rd_en = 1'b1;
    slave_rd_bit = 1'($urandom);
    // Link clock edges land on odd times in passes 0, 2, 4 and 6; the other passes put them on core clock edges
    for (int i = 0; i < 8; i++) begin
      tb_sda = 1'($urandom);
      exp_bit.push_back(tb_sda);
      #61 tb_sclk = 1'b1;
      #64 tb_sclk = 1'b0;
    end
    chk("cs_active", cs_active, 1);
    chk("miso_oe", strap_high_miso_oe, 1);
    chk("miso_o", strap_high_miso_o, slave_rd_bit);
    chk("sclk_oe", sclk_oe, 0);
    chk("bit count", exp_bit.size(), 0);
    tb_cs = 1'b1;
    slave_rd_en = 1'b0;
    repeat (8) @(negedge core_clk);
    chk("cs_active", cs_active, 0);
    chk("miso_oe", strap_high_miso_oe, 0);
    exp_byte.push_back(rd_byte);
    boot(2'h2, 1'b0);
    chk("cs_oe", strap_low_cs_oe, 1);
    chk("cs_o", strap_low_cs_o, 0);
    chk("sclk_oe", sclk_oe, 1);
    for (int k = 0; k < 3000 && boot_done !== 1'b1; k++) @(negedge core_clk);
    chk("boot_done", boot_done, 1);
    chk("cs_oe", strap_low_cs_oe, 0);
    chk("sclk_oe", sclk_oe, 0);
    chk("read command", cmd, 32'h03000000);
    chk("byte count", exp_byte.size(), 0);
    print_verdict();
  end
endmodule : host_pin_roles_tb_top
